/* File: hdl/csc_pkg.sv */
// package: register map, field layout and types of the camera strobe capture block
`default_nettype none
package csc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W              = 16;
  localparam logic [15:0] IDX_LINE_DELAY      = 16'h2020;
  localparam logic [15:0] IDX_PULSE_WIDTH     = 16'h2022;
  localparam logic [15:0] IDX_STROBE_SETTING  = 16'h2024;
  localparam logic [15:0] IDX_CAPTURE_STATUS  = 16'h2026;
  localparam logic [15:0] IDX_CAPTURE_CTRL    = 16'h2030;
  localparam logic [15:0] IDX_CAPTURE_CMD     = 16'h2032;
  localparam logic [15:0] IDX_INT_STATUS      = 16'h2034;
  localparam logic [15:0] IDX_INT_MASK        = 16'h2036;
  localparam int unsigned IDX_SHIFT           = 2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned SET_REQ_FLAG        = 15;
  localparam int unsigned SET_CAM_EN          = 11;
  localparam int unsigned SET_DELAY_LSB       = 4;
  localparam int unsigned SET_POLARITY        = 1;
  localparam int unsigned SET_PORT_EN         = 0;
  localparam int unsigned ST_BUSY             = 3;
  localparam int unsigned ST_STARTED          = 2;
  localparam int unsigned ST_FRAME_INT        = 1;
  localparam int unsigned CTRL_CAM_EN         = 0;
  localparam int unsigned CTRL_SINGLE         = 1;
  localparam int unsigned CMD_SW_RESET        = 0;
  localparam int unsigned CMD_STOP            = 2;
  localparam int unsigned CMD_START           = 3;
  localparam int unsigned EV_FRAME_DONE       = 0;
  localparam int unsigned EV_CAM_REQUEST      = 1;
  localparam int unsigned EV_STROBE_START     = 2;
  localparam int unsigned NUM_EVENTS          = 3;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] LINE_DELAY_RST      = 16'h0000;
  localparam logic [15:0] PULSE_WIDTH_RST     = 16'h0000;
  localparam logic [3:0]  CAP_DELAY_RST       = 4'h0;
  localparam logic        STARTED_RST         = 1'b1;
  localparam logic [2:0]  REQ_HOLD_CLKS       = 3'h4;

  typedef struct packed {
    logic pclk;
    logic frame_ref;
    logic line_ref;
  } csc_cam_type;

  typedef enum logic [1:0] {
    CSC_IDLE       = 2'b00,
    CSC_WAIT_FRAME = 2'b01,
    CSC_DELAY      = 2'b11,
    CSC_PULSE      = 2'b10
  } csc_state_type;

endpackage
`default_nettype wire

/* File: hdl/csc_top.sv */
// camera strobe timing generator with capture status and apb register file
//
// Contract
// - read-only busy bit is one while camera frames are being captured.
// - read-only bit is one under start command, zero under stop command.
// - reset and camera software reset leave capture state at started.
// - read-only bit shows one once the frame capture interrupt occurred.
// - strobe starts programmed lines after first line falling edge in frame.
// - strobe stays active for programmed width plus one lines.
// - line high, frame low for 4 camera clocks sets request flag.
// - camera request flag clears at the end of every frame.
// - camera strobe enable lets a camera request trigger the strobe.
// - repeat mode capture delay sets frames captured after the strobe.
// - single frame mode ignores capture delay, acting as no delay.
// - delay field binary value is frame count, zero is no delay.
// - polarity bit selects active low (default) or active high strobe.
// - stop triggers strobe in repeat mode, start in single mode.
`default_nettype none
module csc_top
  import csc_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned DLY_W = 4
)(
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [csc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire csc_pkg::csc_cam_type      cam_in,
  output logic                           flash_pulse_out,
  output logic                           irq
);
  import csc_pkg::*;

  // ----------------------------------------------------------------
  // camera input synchronisers and edge detection
  // ----------------------------------------------------------------
  csc_cam_type cam_meta_reg;
  csc_cam_type cam_sync_reg;
  csc_cam_type cam_last_reg;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cam_meta_reg <= '0;
      cam_sync_reg <= '0;
      cam_last_reg <= '0;
    end
    else
    begin
      cam_meta_reg <= cam_in;
      cam_sync_reg <= cam_meta_reg;
      cam_last_reg <= cam_sync_reg;
    end
  end

  logic pclk_rise;
  logic frame_start;
  logic frame_end;
  logic line_fall;
  assign pclk_rise   = cam_sync_reg.pclk & ~cam_last_reg.pclk;
  assign frame_start = cam_sync_reg.frame_ref & ~cam_last_reg.frame_ref;
  assign frame_end   = ~cam_sync_reg.frame_ref & cam_last_reg.frame_ref;
  assign line_fall   = ~cam_sync_reg.line_ref & cam_last_reg.line_ref;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]      line_delay_reg;
  logic [CNT_W-1:0]      pulse_width_reg;
  logic                  cam_strobe_en_reg;
  logic [DLY_W-1:0]      cap_delay_reg;
  logic                  polarity_reg;
  logic                  port_en_reg;
  logic                  cam_en_reg;
  logic                  single_mode_reg;
  logic [NUM_EVENTS-1:0] int_mask_reg;
  logic [NUM_EVENTS-1:0] int_stat_reg;
  logic                  cam_req_reg;
  logic                  started_reg;
  logic                  busy_reg;

  logic [ADDR_W-1:0] idx;
  logic              setup;
  logic              access;
  logic              wr;
  logic              cmd_wr;
  logic              sw_reset;
  logic              start_cmd;
  logic              stop_cmd;
  logic              hit;
  logic [31:0]       rd_value;

  assign idx       = {{IDX_SHIFT{1'b0}}, paddr[ADDR_W-1:IDX_SHIFT]};
  assign setup     = psel & ~penable;
  assign access    = psel & penable & pready;
  assign wr        = access & pwrite;
  assign cmd_wr    = wr & (idx == IDX_CAPTURE_CMD);
  assign sw_reset  = cmd_wr & pwdata[CMD_SW_RESET];
  assign start_cmd = cmd_wr & pwdata[CMD_START];
  assign stop_cmd  = cmd_wr & pwdata[CMD_STOP];

  always_comb
  begin
    hit      = 1'b1;
    rd_value = '0;
    case (idx)
      IDX_LINE_DELAY:     rd_value[CNT_W-1:0] = line_delay_reg;
      IDX_PULSE_WIDTH:    rd_value[CNT_W-1:0] = pulse_width_reg;
      IDX_STROBE_SETTING:
      begin
        rd_value[SET_REQ_FLAG]                         = cam_req_reg;
        rd_value[SET_CAM_EN]                           = cam_strobe_en_reg;
        rd_value[SET_DELAY_LSB +: DLY_W]               = cap_delay_reg;
        rd_value[SET_POLARITY]                         = polarity_reg;
        rd_value[SET_PORT_EN]                          = port_en_reg;
      end
      IDX_CAPTURE_STATUS:
      begin
        rd_value[ST_BUSY]      = busy_reg;
        rd_value[ST_STARTED]   = started_reg;
        rd_value[ST_FRAME_INT] = int_stat_reg[EV_FRAME_DONE];
      end
      IDX_CAPTURE_CTRL:
      begin
        rd_value[CTRL_CAM_EN] = cam_en_reg;
        rd_value[CTRL_SINGLE] = single_mode_reg;
      end
      IDX_CAPTURE_CMD:    rd_value = '0;
      IDX_INT_STATUS:     rd_value[NUM_EVENTS-1:0] = int_stat_reg;
      IDX_INT_MASK:       rd_value[NUM_EVENTS-1:0] = int_mask_reg;
      default:            hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // apb answer: one access cycle, no extra wait
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup)
        prdata <= (hit && !pwrite) ? rd_value : '0;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      line_delay_reg    <= LINE_DELAY_RST;
      pulse_width_reg   <= PULSE_WIDTH_RST;
      cam_strobe_en_reg <= 1'b0;
      cap_delay_reg     <= CAP_DELAY_RST;
      polarity_reg      <= 1'b0;
      port_en_reg       <= 1'b0;
      cam_en_reg        <= 1'b0;
      single_mode_reg   <= 1'b0;
      int_mask_reg      <= '0;
    end
    else if (wr)
    begin
      case (idx)
        IDX_LINE_DELAY:  line_delay_reg  <= pwdata[CNT_W-1:0];
        IDX_PULSE_WIDTH: pulse_width_reg <= pwdata[CNT_W-1:0];
        IDX_STROBE_SETTING:
        begin
          cam_strobe_en_reg <= pwdata[SET_CAM_EN];
          cap_delay_reg     <= pwdata[SET_DELAY_LSB +: DLY_W];
          polarity_reg      <= pwdata[SET_POLARITY];
          port_en_reg       <= pwdata[SET_PORT_EN];
        end
        IDX_CAPTURE_CTRL:
        begin
          cam_en_reg      <= pwdata[CTRL_CAM_EN];
          single_mode_reg <= pwdata[CTRL_SINGLE];
        end
        IDX_INT_MASK: int_mask_reg <= pwdata[NUM_EVENTS-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // camera strobe request detection
  // ----------------------------------------------------------------
  logic [2:0] req_cnt_reg;
  logic       req_hold;
  logic       cam_req_set;
  assign req_hold    = cam_sync_reg.line_ref & ~cam_sync_reg.frame_ref;
  assign cam_req_set = req_hold & pclk_rise & (req_cnt_reg == REQ_HOLD_CLKS - 3'h1) & ~cam_req_reg;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      req_cnt_reg <= '0;
    else if (!req_hold || sw_reset)
      req_cnt_reg <= '0;
    else if (pclk_rise && req_cnt_reg != REQ_HOLD_CLKS)
      req_cnt_reg <= req_cnt_reg + 3'h1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cam_req_reg <= 1'b0;
    else if (cam_req_set)
      cam_req_reg <= 1'b1;
    else if (frame_end || sw_reset)
      cam_req_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // strobe sequencer
  // ----------------------------------------------------------------
  csc_state_type    state_reg;
  logic [CNT_W-1:0] line_cnt_reg;
  logic             trigger;
  logic             pulse_begin;

  assign trigger = port_en_reg &
                   ((stop_cmd & ~single_mode_reg) |
                    (start_cmd & single_mode_reg) |
                    (cam_req_set & cam_strobe_en_reg));
  assign pulse_begin = (state_reg == CSC_DELAY) & line_fall & ~frame_start & (line_cnt_reg == line_delay_reg);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= CSC_IDLE;
      line_cnt_reg <= '0;
    end
    else if (sw_reset || !port_en_reg)
    begin
      state_reg    <= CSC_IDLE;
      line_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        CSC_IDLE:
          if (trigger)
            state_reg <= CSC_WAIT_FRAME;
        CSC_WAIT_FRAME:
          if (frame_start)
          begin
            state_reg    <= CSC_DELAY;
            line_cnt_reg <= '0;
          end
        CSC_DELAY:
          if (frame_start)
            line_cnt_reg <= '0;
          else if (line_fall)
          begin
            if (pulse_begin)
            begin
              state_reg    <= CSC_PULSE;
              line_cnt_reg <= '0;
            end
            else
              line_cnt_reg <= line_cnt_reg + CNT_W'(1);
          end
        CSC_PULSE:
          if (frame_start)
          begin
            state_reg    <= CSC_DELAY;
            line_cnt_reg <= '0;
          end
          else if (line_fall)
          begin
            if (line_cnt_reg == pulse_width_reg)
              state_reg <= CSC_IDLE;
            else
              line_cnt_reg <= line_cnt_reg + CNT_W'(1);
          end
        default: state_reg <= CSC_IDLE;
      endcase
    end
  end

  // inactive level follows polarity even while disabled, so the flash never fires by accident
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      flash_pulse_out <= 1'b1;
    else
      flash_pulse_out <= (state_reg == CSC_PULSE) ? polarity_reg : ~polarity_reg;
  end

  // ----------------------------------------------------------------
  // capture state and frame delay after strobe
  // ----------------------------------------------------------------
  logic             single_pending_reg;
  logic             stop_wait_reg;
  logic [DLY_W-1:0] frames_left_reg;
  logic             allow;
  logic             frame_done;

  assign allow      = cam_en_reg & (single_mode_reg ? single_pending_reg
                                    : (started_reg | stop_wait_reg | (frames_left_reg != '0)));
  assign frame_done = frame_end & busy_reg;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      started_reg <= STARTED_RST;
    else if (sw_reset)
      started_reg <= STARTED_RST;
    else if (start_cmd)
      started_reg <= 1'b1;
    else if (stop_cmd)
      started_reg <= 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      single_pending_reg <= 1'b0;
    else if (sw_reset)
      single_pending_reg <= 1'b0;
    else if (start_cmd)
      single_pending_reg <= 1'b1;
    else if (frame_done && single_mode_reg)
      single_pending_reg <= 1'b0;
  end

  // in repeat mode a strobed stop keeps capturing until the strobe, then for the delay count
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stop_wait_reg   <= 1'b0;
      frames_left_reg <= '0;
    end
    else if (sw_reset || start_cmd)
    begin
      stop_wait_reg   <= 1'b0;
      frames_left_reg <= '0;
    end
    else if (stop_cmd)
    begin
      stop_wait_reg   <= port_en_reg & ~single_mode_reg;
      frames_left_reg <= '0;
    end
    else if (pulse_begin && stop_wait_reg)
    begin
      stop_wait_reg   <= 1'b0;
      frames_left_reg <= cap_delay_reg;
    end
    // counted at frame start, so the strobe frame itself does not use up a delay frame
    else if (frame_start && !started_reg && !stop_wait_reg && frames_left_reg != '0)
      frames_left_reg <= frames_left_reg - DLY_W'(1);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      busy_reg <= 1'b0;
    else if (sw_reset || frame_end)
      busy_reg <= 1'b0;
    else if (frame_start)
      busy_reg <= allow;
  end

  // ----------------------------------------------------------------
  // interrupt status: read clears only the bits returned, set wins
  // ----------------------------------------------------------------
  logic [NUM_EVENTS-1:0] ev;
  logic [NUM_EVENTS-1:0] rd_clr;
  assign ev[EV_FRAME_DONE]   = frame_done;
  assign ev[EV_CAM_REQUEST]  = cam_req_set;
  assign ev[EV_STROBE_START] = pulse_begin;
  assign rd_clr = (access && !pwrite && idx == IDX_INT_STATUS) ? prdata[NUM_EVENTS-1:0] : '0;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      int_stat_reg <= '0;
    else
      int_stat_reg <= (int_stat_reg & ~rd_clr) | ev;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(int_stat_reg & int_mask_reg);
  end

endmodule
`default_nettype wire

/* File: verif/csc_checker.sv */
// port assertions for the camera strobe capture block
`default_nettype none
module csc_checker
  import csc_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned DLY_W = 4
)(
  input wire logic                       clock,
  input wire logic                       nrst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [csc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire csc_pkg::csc_cam_type       cam_in,
  input wire logic                       flash_pulse_out,
  input wire logic                       irq
);
  import csc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read_done;
    pready && !pwrite;
  endsequence
  // line held high long enough that any strobe edge from the last fall has landed
  sequence s_line_quiet;
    cam_in.line_ref [*8] ##0 (!psel && !$past(psel) && !$past(psel, 2));
  endsequence

  property p_ready_after_setup;
    s_setup |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  property p_bad_read_zero;
    s_read_done ##0 pslverr |-> prdata == 32'h0;
  endproperty
  property p_upper_zero;
    s_read_done |-> prdata[31:16] == 16'h0;
  endproperty
  property p_cmd_reads_zero;
    s_read_done ##0 (paddr[15:2] == IDX_CAPTURE_CMD[13:0]) |-> prdata == 32'h0;
  endproperty
  property p_idle_after_reset;
    $rose(nrst) |-> flash_pulse_out && !irq;
  endproperty
  property p_flash_on_line_fall;
    s_line_quiet |-> $stable(flash_pulse_out);
  endproperty

  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  a_bad_read_zero: assert property (p_bad_read_zero) else $error("unmapped read not zero");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command register read not zero");
  a_idle_after_reset: assert property (p_idle_after_reset) else $error("strobe or irq active at reset");
  a_flash_on_line_fall: assert property (p_flash_on_line_fall) else $error("strobe moved mid line");
endmodule

bind csc_top csc_checker #(.CNT_W(CNT_W), .DLY_W(DLY_W)) chk_u (.clock(clock), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cam_in(cam_in), .flash_pulse_out(flash_pulse_out), .irq(irq));
`default_nettype wire

/* File: verif/csc_cam_model.sv */
// behavioural camera sensor: frame and line references and a gated pixel clock
`default_nettype none
module csc_cam_model
  import csc_pkg::*;
(
  output var csc_pkg::csc_cam_type cam
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cam = '0;
  // pixel clock stands still outside frames and requests
  task automatic tick(input int n);
    repeat (n)
    begin
      #80 cam.pclk = 1'b1;
      #80 cam.pclk = 1'b0;
    end
  endtask
  // pins move off the system clock edges, as real camera pins would
  task automatic frame(input int lines);
    #5;
    cam.frame_ref = 1'b1;
    tick(2);
    repeat (lines)
    begin
      cam.line_ref = 1'b1;
      tick(4);
      cam.line_ref = 1'b0;
      tick(4);
    end
    cam.frame_ref = 1'b0;
    tick(2);
  endtask
  task automatic request();
    #5;
    cam.line_ref = 1'b1;
    tick(4);
    cam.line_ref = 1'b0;
    tick(1);
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench: apb register tests and strobe timing against a camera model
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench
  import csc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, nrst, psel, penable, pwrite, pready, pslverr, flash_pulse_out, irq;
  logic        act, was, lp, fp, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  csc_cam_type cam;
  int          n_errors, check_count, falls, t_on, t_off;

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  csc_top dut_u (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cam_in(cam),
    .flash_pulse_out(flash_pulse_out), .irq(irq));
  csc_cam_model cam_u (.cam(cam));

  // line falls counted from each frame start; strobe edges logged against them
  always @(posedge clock)
  begin
    lp <= cam.line_ref;
    fp <= cam.frame_ref;
    if (cam.frame_ref && !fp)
      falls <= 0;
    else if (lp && !cam.line_ref)
      falls <= falls + 1;
    if ((flash_pulse_out === act) && !was)
      t_on <= falls;
    if ((flash_pulse_out !== act) && was)
      t_off <= falls;
    was <= (flash_pulse_out === act);
  end

  task automatic apb(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge clock);
    end
    if (n == 16) `CHK("pready", 1'b1, 1'b0)
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic frame_busy(input int lines, input logic exp);
    fork
      cam_u.frame(lines);
      begin
        repeat (40) @(posedge clock);
        apb(IDX_CAPTURE_STATUS, 1'b0, 32'h0);
        `CHK("busy", exp, rd[ST_BUSY]);
      end
    join
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    {nrst, psel, penable, pwrite, act, was, lp, fp} = '0;
    paddr = 16'h0;
    pwdata = 32'h0;
    {n_errors, check_count, falls, t_on, t_off} = '0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    apb(IDX_STROBE_SETTING, 1'b0, 32'h0);
    `CHK("setting", 32'h0, rd);
    apb(IDX_CAPTURE_STATUS, 1'b0, 32'h0);
    `CHK("status", 32'h4, rd & 32'he);
    `CHK("flash idle", 1'b1, flash_pulse_out);
    apb(16'h2028, 1'b0, 32'h0);
    `CHK("unmapped err", 1'b1, err);
    $display("test reset done");
    // repeat mode, one delay frame, active high
    apb(IDX_LINE_DELAY, 1'b1, 32'h2);
    apb(IDX_PULSE_WIDTH, 1'b1, 32'h1);
    apb(IDX_STROBE_SETTING, 1'b1, 32'h13);
    apb(IDX_CAPTURE_CMD, 1'b1, 32'h4);
    apb(IDX_CAPTURE_CTRL, 1'b1, 32'h1);
    act = 1'b1;
    frame_busy(6, 1'b1);
    `CHK("on", 3, t_on);
    `CHK("off", 5, t_off);
    apb(IDX_CAPTURE_STATUS, 1'b0, 32'h0);
    `CHK("status", 32'h2, rd & 32'he);
    frame_busy(2, 1'b1);
    frame_busy(2, 1'b0);
    $display("test repeat done");
    // single mode: delay field ignored, active low
    apb(IDX_STROBE_SETTING, 1'b1, 32'hf1);
    apb(IDX_LINE_DELAY, 1'b1, 32'h0);
    apb(IDX_PULSE_WIDTH, 1'b1, 32'h0);
    apb(IDX_CAPTURE_CTRL, 1'b1, 32'h3);
    apb(IDX_CAPTURE_CMD, 1'b1, 32'h8);
    act = 1'b0;
    frame_busy(3, 1'b1);
    `CHK("on", 1, t_on);
    `CHK("off", 2, t_off);
    frame_busy(2, 1'b0);
    $display("test single done");
    // software reset, camera request and its interrupt
    apb(IDX_CAPTURE_CMD, 1'b1, 32'h1);
    apb(IDX_CAPTURE_STATUS, 1'b0, 32'h0);
    `CHK("started", 1'b1, rd[ST_STARTED]);
    apb(IDX_CAPTURE_CTRL, 1'b1, 32'h1);
    apb(IDX_LINE_DELAY, 1'b1, 32'h2);
    apb(IDX_PULSE_WIDTH, 1'b1, 32'h1);
    apb(IDX_STROBE_SETTING, 1'b1, 32'h803);
    apb(IDX_INT_MASK, 1'b1, 32'h0);
    apb(IDX_INT_STATUS, 1'b0, 32'h0);
    act = 1'b1;
    cam_u.request();
    apb(IDX_STROBE_SETTING, 1'b0, 32'h0);
    `CHK("req flag", 1'b1, rd[SET_REQ_FLAG]);
    `CHK("irq masked", 1'b0, irq);
    apb(IDX_INT_MASK, 1'b1, 32'h2);
    repeat (3) @(posedge clock);
    `CHK("irq", 1'b1, irq);
    apb(IDX_INT_STATUS, 1'b0, 32'h0);
    `CHK("int req", 1'b1, rd[EV_CAM_REQUEST]);
    repeat (3) @(posedge clock);
    `CHK("irq clr", 1'b0, irq);
    cam_u.frame(6);
    `CHK("on", 3, t_on);
    `CHK("off", 5, t_off);
    apb(IDX_INT_STATUS, 1'b0, 32'h0);
    `CHK("int frame strobe", 32'h5, rd);
    apb(IDX_STROBE_SETTING, 1'b0, 32'h0);
    `CHK("req flag", 1'b0, rd[SET_REQ_FLAG]);
    $display("test camera request done");
    wrap_up();
  end
endmodule
`default_nettype wire
